//--- include/ddr_init_pkg.sv
// constants, command carrier and states of the ddr init controller
package ddr_init_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ   = 20;
  localparam int STABLE_TIME_US = 200;
  localparam int TIMER_W        = 12;
  localparam logic [TIMER_W-1:0] STABLE_CYC   = TIMER_W'(STABLE_TIME_US * CLK_FREQ_MHZ);
  localparam logic [TIMER_W-1:0] DLL_LOCK_CYC = 12'h0C8;
  localparam logic [TIMER_W-1:0] MRD_CYC      = 12'h002;
  localparam logic [TIMER_W-1:0] RP_CYC       = 12'h002;
  localparam logic [TIMER_W-1:0] RFC_CYC      = 12'h008;
  localparam logic [TIMER_W-1:0] NOP_CYC      = 12'h001;
  localparam logic [3:0]         REFRESH_MIN  = 4'h2;

  // ---------------------------------------------------------------
  // software register map
  // ---------------------------------------------------------------
  localparam int SW_ADDR_W = 4;
  localparam logic [SW_ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [SW_ADDR_W-1:0] MODE_OFS   = 4'h4;
  localparam logic [SW_ADDR_W-1:0] STATUS_OFS = 4'h8;
  localparam logic [SW_ADDR_W-1:0] BURST_OFS  = 4'hC;

  localparam int CTRL_START_BIT     = 0;
  localparam int CTRL_SKIP_RST_BIT  = 1;
  localparam int CTRL_PRE_FIRST_BIT = 2;
  localparam int CTRL_REWRITE_BIT   = 3;

  localparam int MODE_BL_LSB   = 0;
  localparam int MODE_TYPE_BIT = 3;
  localparam int MODE_CL_LSB   = 4;
  localparam int MODE_W        = 7;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h23;

  localparam int STAT_READY_BIT = 4;
  localparam int STAT_DLL_BIT   = 5;
  localparam int STAT_FET_BIT   = 6;

  // ---------------------------------------------------------------
  // mode register fields on the address pins
  // ---------------------------------------------------------------
  localparam int ADDR_W       = 12;
  localparam int A_TEST_BIT   = 7;
  localparam int A_DLLRST_BIT = 8;
  localparam int A_ALLBANK    = 10;
  localparam int A_DLLDIS_BIT = 0;

  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;

  localparam logic [1:0] BA_MODE     = 2'h0;
  localparam logic [1:0] BA_EXT_MODE = 2'h1;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LMR     = 4'h0;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
  } ddr_cmd_t;

  localparam ddr_cmd_t PINS_RESET = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                      we_n: 1'b1, ba: 2'h0, addr: 12'h000};

  // gray codes along the default init path; the pre_first and skip_dll_rst branches step two bits
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_WAIT_CLK = 4'h1,
    ST_WAKE     = 4'h3,
    ST_PRE1     = 4'h2,
    ST_EXT_MODE = 4'h6,
    ST_DLL_RST  = 4'h7,
    ST_PRE2     = 4'h5,
    ST_REFRESH  = 4'h4,
    ST_MODE_RUN = 4'hC,
    ST_SETTLE   = 4'hD,
    ST_READY    = 4'hF,
    ST_REWRITE  = 4'hE
  } init_state_t;

endpackage

//--- hdl/countdown_timer.sv
// loadable down counter that flags when its gap has run out
module countdown_timer #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // status
  output logic              done
);

  logic [W-1:0] count;

  assign done = (count == '0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (!done) begin
      count <= count - 1'b1;
    end
  end

endmodule

//--- hdl/burst_order.sv
// column order of a burst for the programmed length and addressing mode
module burst_order (
  // burst setup
  input  wire logic [2:0]  start_col,
  input  wire logic [2:0]  len_code,
  input  wire logic        interleave,
  // eight 3-bit columns, beat 0 in the low bits, unused beats zero
  output logic      [23:0] order
);

  logic [2:0] mask;

  assign mask = (len_code == ddr_init_pkg::BL_CODE_8) ? 3'h7 :
                (len_code == ddr_init_pkg::BL_CODE_4) ? 3'h3 :
                (len_code == ddr_init_pkg::BL_CODE_2) ? 3'h1 : 3'h0;

  for (genvar i = 0; i < 8; i++) begin : g_beat
    wire logic [2:0] beat = 3'(i);
    wire logic [2:0] low  = interleave ? ((start_col ^ beat) & mask)
                                       : ((start_col + beat) & mask);
    assign order[3*i +: 3] = ((beat & ~mask) == 3'h0) ? ((start_col & ~mask) | low) : 3'h0;
  end

endmodule

//--- hdl/ddr_init_ctl.sv
// host-side power-up and mode register controller for a ddr sdram
// ---------------------------------------------------------------
// Notes on behaviour
// R1 - device may drive fet isolation output during reads and writes
// R2 - clock enable held low from reset until the clock wait ends
// R3 - clock runs at least 200 us before any command
// R4 - after the wait, drive nop and raise clock enable
// R5 - precharge all banks before the extended mode write
// R6 - extended mode write enables dll: a0 low, ba0 high, rest low
// R7 - mode write with a8 high resets dll; allow 200 lock cycles
// R8 - second all-bank precharge follows the dll reset
// R9 - at least two auto-refresh commands after second precharge
// R10 - final mode write with a8 low starts normal operation
// R11 - dll reset write may be skipped; lock wait still counted
// R12 - dll reset write and second precharge in either order
// R13 - mode register written after extended mode, before normal use
// R14 - device loads mode register when cs, ras, cas, we, ba0 low
// R15 - mode writes only with banks precharged and clock enable high
// R16 - two cycles after a mode write before the next command
// R17 - mode register may be rewritten later while banks idle
// R18 - fields: length a0-a2, mode a3, latency a4-a6, test a7, dll a8
// R19 - test bit a7 kept low on every mode write
// R20 - sequential burst wraps inside the aligned block
// R21 - interleave burst column is start xor beat
// R22 - 200 cycles after dll enable before any read
// ---------------------------------------------------------------
module ddr_init_ctl (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // software port
  input  wire logic [3:0]           sw_addr,
  input  wire logic [31:0]          sw_wdata,
  input  wire logic                 sw_wr,
  input  wire logic                 sw_rd,
  output logic      [31:0]          sw_rdata,
  // memory pins
  output logic                      ddr_clk_run,
  output ddr_init_pkg::ddr_cmd_t    ddr_pins,
  input  wire logic                 fet_isolation_ctl,
  // status
  output logic                      init_done
);

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic                             skip_dll_rst;
  logic                             pre_first;
  logic [ddr_init_pkg::MODE_W-1:0]  mode;
  logic [2:0]                       burst_start;
  logic                             start_req;
  logic                             rewrite_req;

  wire logic wr_ctrl  = sw_wr && (sw_addr == ddr_init_pkg::CTRL_OFS);
  wire logic wr_mode  = sw_wr && (sw_addr == ddr_init_pkg::MODE_OFS);
  wire logic wr_burst = sw_wr && (sw_addr == ddr_init_pkg::BURST_OFS);

  ddr_init_pkg::init_state_t state;
  ddr_init_pkg::init_state_t next_state;

  wire logic start_taken   = (state == ddr_init_pkg::ST_IDLE) || (state == ddr_init_pkg::ST_READY);
  wire logic rewrite_taken = (state == ddr_init_pkg::ST_READY) && !start_req;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      skip_dll_rst <= 1'b0;
      pre_first    <= 1'b0;
      mode         <= ddr_init_pkg::MODE_RESET;
      burst_start  <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        skip_dll_rst <= sw_wdata[ddr_init_pkg::CTRL_SKIP_RST_BIT];
        pre_first    <= sw_wdata[ddr_init_pkg::CTRL_PRE_FIRST_BIT];
      end
      if (wr_mode) begin
        mode <= sw_wdata[ddr_init_pkg::MODE_W-1:0];
      end
      if (wr_burst) begin
        burst_start <= sw_wdata[2:0];
      end
    end
  end

  // requests stay pending until the sequencer can take them; new write wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_req   <= 1'b0;
      rewrite_req <= 1'b0;
    end else begin
      start_req   <= (wr_ctrl && sw_wdata[ddr_init_pkg::CTRL_START_BIT]) || (start_req && !start_taken);
      rewrite_req <= (wr_ctrl && sw_wdata[ddr_init_pkg::CTRL_REWRITE_BIT]) ||
                     (rewrite_req && !rewrite_taken);
    end
  end

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  logic fet_meta;
  logic fet_sync;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fet_meta <= 1'b0;
      fet_sync <= 1'b0;
    end else begin
      fet_meta <= fet_isolation_ctl;
      fet_sync <= fet_meta; // R1
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  logic                              gap_load;
  logic [ddr_init_pkg::TIMER_W-1:0]  gap_value;
  logic                              gap_done;
  logic                              dll_load;
  logic                              dll_done;
  logic                              dll_armed;

  countdown_timer #(.W(ddr_init_pkg::TIMER_W)) u_gap_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .load    (gap_load),
    .value   (gap_value),
    .done    (gap_done)
  );

  countdown_timer #(.W(ddr_init_pkg::TIMER_W)) u_dll_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .load    (dll_load),
    .value   (ddr_init_pkg::DLL_LOCK_CYC),
    .done    (dll_done)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dll_armed <= 1'b0;
    end else if (dll_load) begin
      dll_armed <= 1'b1;
    end else if (state == ddr_init_pkg::ST_IDLE) begin
      dll_armed <= 1'b0;
    end
  end

  wire logic dll_locked = dll_armed && dll_done; // R22

  // ---------------------------------------------------------------
  // command words
  // ---------------------------------------------------------------
  logic [3:0] ref_count;

  wire logic [ddr_init_pkg::ADDR_W-1:0] mode_word =
    ddr_init_pkg::ADDR_W'(mode) & ~(12'h001 << ddr_init_pkg::A_TEST_BIT); // R18 R19
  wire logic [ddr_init_pkg::ADDR_W-1:0] dll_rst_word =
    mode_word | (12'h001 << ddr_init_pkg::A_DLLRST_BIT); // R7
  wire logic [ddr_init_pkg::ADDR_W-1:0] all_bank_word =
    12'h001 << ddr_init_pkg::A_ALLBANK;
  wire logic [ddr_init_pkg::ADDR_W-1:0] ext_word =
    12'h000 & ~(12'h001 << ddr_init_pkg::A_DLLDIS_BIT); // R6

  function automatic ddr_init_pkg::ddr_cmd_t cmd(input logic [3:0] code, input logic [1:0] ba,
                                                 input logic [11:0] addr);
    cmd = '{cke: 1'b1, cs_n: code[3], ras_n: code[2], cas_n: code[1], we_n: code[0],
            ba: ba, addr: addr};
  endfunction

  wire ddr_init_pkg::ddr_cmd_t nop_cmd = cmd(ddr_init_pkg::CMD_NOP, 2'h0, 12'h000);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  ddr_init_pkg::ddr_cmd_t next_pins;
  logic                   ref_inc;

  always_comb begin
    next_state = state;
    next_pins  = nop_cmd;
    gap_load   = 1'b0;
    gap_value  = ddr_init_pkg::NOP_CYC;
    dll_load   = 1'b0;
    ref_inc    = 1'b0;
    case (state)
      ddr_init_pkg::ST_IDLE: begin
        next_pins = ddr_init_pkg::PINS_RESET; // R2
        if (start_req) begin
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::STABLE_CYC; // R3
          next_state = ddr_init_pkg::ST_WAIT_CLK;
        end
      end
      ddr_init_pkg::ST_WAIT_CLK: begin
        next_pins = ddr_init_pkg::PINS_RESET; // R2
        if (gap_done) begin
          gap_load   = 1'b1;
          next_state = ddr_init_pkg::ST_WAKE;
        end
      end
      ddr_init_pkg::ST_WAKE: begin
        if (gap_done) begin
          next_pins  = nop_cmd; // R4
          gap_load   = 1'b1;
          next_state = ddr_init_pkg::ST_PRE1;
        end
      end
      ddr_init_pkg::ST_PRE1: begin
        if (gap_done) begin
          next_pins  = cmd(ddr_init_pkg::CMD_PRE, 2'h0, all_bank_word); // R5
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::RP_CYC;
          next_state = ddr_init_pkg::ST_EXT_MODE;
        end
      end
      ddr_init_pkg::ST_EXT_MODE: begin
        if (gap_done) begin
          next_pins  = cmd(ddr_init_pkg::CMD_LMR, ddr_init_pkg::BA_EXT_MODE, ext_word); // R6 R15
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::MRD_CYC; // R16
          dll_load   = 1'b1; // R11
          next_state = (skip_dll_rst || pre_first) ? ddr_init_pkg::ST_PRE2
                                                   : ddr_init_pkg::ST_DLL_RST; // R11 R12
        end
      end
      ddr_init_pkg::ST_DLL_RST: begin
        if (gap_done) begin
          next_pins  = cmd(ddr_init_pkg::CMD_LMR, ddr_init_pkg::BA_MODE, dll_rst_word); // R7 R13
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::MRD_CYC; // R16
          dll_load   = 1'b1; // R7
          next_state = pre_first ? ddr_init_pkg::ST_REFRESH : ddr_init_pkg::ST_PRE2; // R12
        end
      end
      ddr_init_pkg::ST_PRE2: begin
        if (gap_done) begin
          next_pins  = cmd(ddr_init_pkg::CMD_PRE, 2'h0, all_bank_word); // R8
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::RP_CYC;
          next_state = (pre_first && !skip_dll_rst) ? ddr_init_pkg::ST_DLL_RST
                                                    : ddr_init_pkg::ST_REFRESH; // R12
        end
      end
      ddr_init_pkg::ST_REFRESH: begin
        if (gap_done) begin
          if (ref_count < ddr_init_pkg::REFRESH_MIN) begin
            next_pins = cmd(ddr_init_pkg::CMD_REFRESH, 2'h0, 12'h000); // R9
            gap_load  = 1'b1;
            gap_value = ddr_init_pkg::RFC_CYC;
            ref_inc   = 1'b1;
          end else begin
            next_state = ddr_init_pkg::ST_MODE_RUN;
          end
        end
      end
      ddr_init_pkg::ST_MODE_RUN: begin
        next_pins  = cmd(ddr_init_pkg::CMD_LMR, ddr_init_pkg::BA_MODE, mode_word); // R10 R13 R15
        gap_load   = 1'b1;
        gap_value  = ddr_init_pkg::MRD_CYC; // R16
        next_state = ddr_init_pkg::ST_SETTLE;
      end
      ddr_init_pkg::ST_SETTLE: begin
        if (gap_done && dll_locked) begin
          next_state = ddr_init_pkg::ST_READY; // R22
        end
      end
      ddr_init_pkg::ST_READY: begin
        if (start_req) begin
          next_pins  = ddr_init_pkg::PINS_RESET;
          gap_load   = 1'b1;
          gap_value  = ddr_init_pkg::STABLE_CYC;
          next_state = ddr_init_pkg::ST_WAIT_CLK;
        end else if (rewrite_req) begin
          next_state = ddr_init_pkg::ST_REWRITE;
        end
      end
      ddr_init_pkg::ST_REWRITE: begin
        next_pins  = cmd(ddr_init_pkg::CMD_LMR, ddr_init_pkg::BA_MODE, mode_word); // R17 R19
        gap_load   = 1'b1;
        gap_value  = ddr_init_pkg::MRD_CYC; // R16
        next_state = ddr_init_pkg::ST_SETTLE;
      end
      default: begin
        next_pins  = ddr_init_pkg::PINS_RESET;
        next_state = ddr_init_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state     <= ddr_init_pkg::ST_IDLE;
      ddr_pins  <= ddr_init_pkg::PINS_RESET; // R2
      ref_count <= 4'h0;
    end else begin
      state     <= next_state;
      ddr_pins  <= next_pins;
      ref_count <= (state == ddr_init_pkg::ST_WAKE) ? 4'h0 : ref_count + 4'(ref_inc);
    end
  end

  // ---------------------------------------------------------------
  // outputs and read-back
  // ---------------------------------------------------------------
  logic [23:0] burst_cols;

  burst_order u_burst_order (
    .start_col  (burst_start),
    .len_code   (mode[ddr_init_pkg::MODE_BL_LSB +: 3]),
    .interleave (mode[ddr_init_pkg::MODE_TYPE_BIT]),
    .order      (burst_cols)
  );

  wire logic [31:0] status_word = {25'h0, fet_sync, dll_locked,
                                   state == ddr_init_pkg::ST_READY, state};
  wire logic [31:0] ctrl_word   = {29'h0, pre_first, skip_dll_rst, 1'b0};
  wire logic [31:0] read_word   =
    (sw_addr == ddr_init_pkg::CTRL_OFS)   ? ctrl_word :
    (sw_addr == ddr_init_pkg::MODE_OFS)   ? 32'(mode) :
    (sw_addr == ddr_init_pkg::STATUS_OFS) ? status_word :
    (sw_addr == ddr_init_pkg::BURST_OFS)  ? {5'h0, burst_start, burst_cols} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_rdata    <= 32'h0;
      ddr_clk_run <= 1'b0;
      init_done   <= 1'b0;
    end else begin
      sw_rdata    <= sw_rd ? read_word : 32'h0;
      ddr_clk_run <= (next_state != ddr_init_pkg::ST_IDLE); // R3
      init_done   <= (next_state == ddr_init_pkg::ST_READY);
    end
  end

endmodule

//--- testbench/ddr_init_props.sv
// port assertions for the ddr init controller
module ddr_init_props (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset,
  // software port
  input wire logic [3:0]             sw_addr,
  input wire logic [31:0]            sw_wdata,
  input wire logic                   sw_wr,
  input wire logic                   sw_rd,
  input wire logic [31:0]            sw_rdata,
  // memory pins and status
  input wire logic                   ddr_clk_run,
  input wire ddr_init_pkg::ddr_cmd_t ddr_pins,
  input wire logic                   fet_isolation_ctl,
  input wire logic                   init_done
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STABLE = 4000;
  localparam int LOCK   = 200;
  wire [3:0] cmd     = {ddr_pins.cs_n, ddr_pins.ras_n, ddr_pins.cas_n, ddr_pins.we_n};
  wire       is_lmr  = cmd == ddr_init_pkg::CMD_LMR;
  wire       dll_cmd = is_lmr && (ddr_pins.ba[0] || ddr_pins.addr[8]);
  logic [12:0] run_cnt;
  logic [8:0]  lock_cnt;

  // cycles of running clock and since last dll enable or reset
  always_ff @(posedge sys_clk) begin
    if (reset || !ddr_clk_run) run_cnt <= 13'h0;
    else if (run_cnt != 13'h1FFF) run_cnt <= run_cnt + 13'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (reset || dll_cmd) lock_cnt <= 9'h0;
    else if (lock_cnt != 9'h1FF) lock_cnt <= lock_cnt + 9'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_cke_clk; ddr_pins.cke |-> ddr_clk_run; endproperty
  a_cke_clk: assert property (p_cke_clk)
    else $error("clock enable high with memory clock stopped");
  property p_stable; $rose(ddr_pins.cke) |-> run_cnt >= STABLE - 1; endproperty
  a_stable: assert property (p_stable)
    else $error("clock enable raised before stable clock wait");
  property p_wake;
    $rose(ddr_pins.cke) |-> cmd == ddr_init_pkg::CMD_NOP ##3 cmd == ddr_init_pkg::CMD_PRE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake up not nop then precharge");
  property p_cmd_cke; !ddr_pins.cs_n && cmd != ddr_init_pkg::CMD_NOP |-> ddr_pins.cke && $past(ddr_pins.cke); endproperty
  a_cmd_cke: assert property (p_cmd_cke)
    else $error("command without clock enable already high");
  property p_emrs; is_lmr && ddr_pins.ba == ddr_init_pkg::BA_EXT_MODE |-> ddr_pins.addr == 12'h000; endproperty
  a_emrs: assert property (p_emrs)
    else $error("extended mode write not dll enable code");
  property p_test_low; is_lmr && ddr_pins.ba == ddr_init_pkg::BA_MODE |-> !ddr_pins.addr[7]; endproperty
  a_test_low: assert property (p_test_low)
    else $error("mode write with test bit set");
  property p_mrs_gap; is_lmr |=> cmd == ddr_init_pkg::CMD_NOP ##1 cmd == ddr_init_pkg::CMD_NOP; endproperty
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("command too soon after mode write");
  property p_pre_all; cmd == ddr_init_pkg::CMD_PRE |-> ddr_pins.addr[10]; endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge not for all banks");
  property p_lock; $rose(init_done) |-> lock_cnt >= LOCK - 1; endproperty
  a_lock: assert property (p_lock)
    else $error("ready before dll lock wait");
  property p_done; init_done |-> ddr_pins.cke && ddr_clk_run; endproperty
  a_done: assert property (p_done)
    else $error("ready without running clock");
  property p_rdata_idle; !$past(sw_rd) |-> sw_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  c_ready: cover property ($rose(init_done));
  c_dll_rst: cover property (is_lmr && !ddr_pins.ba[0] && ddr_pins.addr[8]);
  c_emrs: cover property (is_lmr && ddr_pins.ba[0]);
endmodule

//--- testbench/ddr_dev_model.sv
// behavioural sdram command decoder for power-up and mode writes
module ddr_dev_model (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // memory pins
  input  wire logic                   ck_run,
  input  wire ddr_init_pkg::ddr_cmd_t pins,
  output logic                        fet_isolation_ctl,
  // observation
  output logic [11:0]                 mode_reg,
  output logic [11:0]                 ext_reg,
  output logic                        dll_locked,
  output logic [7:0]                  dll_rst_cnt,
  output logic [7:0]                  err_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       ext_done;
  logic       pre_done;
  logic       dll_on;
  logic [8:0] lock;
  logic [3:0] since;
  logic [7:0] refreshes;
  wire [3:0] cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  wire       act = ck_run && pins.cke && !pins.cs_n && cmd != ddr_init_pkg::CMD_NOP;
  wire       lmr = act && cmd == ddr_init_pkg::CMD_LMR;
  wire       bad = (pins.cke && !ck_run)
                || (act && since == 4'h0)
                || (lmr && !pre_done)
                || (lmr && pins.ba[0] && pins.addr != 12'h000)
                || (lmr && !pins.ba[0] && (pins.addr[7] || !ext_done))
                || (lmr && !pins.ba[0] && !pins.addr[8] && refreshes < 8'h2);
  assign dll_locked = dll_on && lock >= 9'h0C8;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_reg <= 12'hFFF;
      ext_reg <= 12'hFFF;
      {ext_done, pre_done, dll_on, fet_isolation_ctl} <= 4'h0;
      {lock, since} <= {9'h0, 4'hF};
      {dll_rst_cnt, err_count, refreshes} <= 24'h0;
    end else begin
      fet_isolation_ctl <= act && (cmd == 4'h5 || cmd == 4'h4);
      err_count <= err_count + {7'h0, bad};
      if (lock != 9'h1FF) lock <= lock + 9'h1;
      if (since != 4'hF) since <= since + 4'h1;
      if (lmr) since <= 4'h0;
      if (act && cmd == ddr_init_pkg::CMD_PRE && pins.addr[10]) begin
        pre_done <= 1'b1;
        refreshes <= 8'h0;
      end
      if (act && cmd == ddr_init_pkg::CMD_REFRESH) refreshes <= refreshes + 8'h1;
      if (lmr && pins.ba[0]) begin
        ext_reg <= pins.addr;
        ext_done <= 1'b1;
        dll_on <= !pins.addr[0];
        lock <= 9'h0;
      end
      if (lmr && !pins.ba[0]) mode_reg <= pins.addr;
      if (lmr && !pins.ba[0] && pins.addr[8]) begin
        lock <= 9'h0;
        dll_rst_cnt <= dll_rst_cnt + 8'h1;
      end
    end
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the ddr init controller
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   sys_clk, reset, sw_wr, sw_rd, ddr_clk_run, init_done, fet_isolation_ctl;
  logic [3:0]             sw_addr;
  logic [31:0]            sw_wdata, sw_rdata;
  ddr_init_pkg::ddr_cmd_t ddr_pins;
  logic [11:0]            mode_reg, ext_reg;
  logic [7:0]             dll_rst_cnt, err_count;
  logic                   dll_locked;
  int                     bad_count = 0;
  int                     checks = 0;
  int                     cyc = 0;

  ddr_init_ctl i_dut (.sys_clk, .reset, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
                      .ddr_clk_run, .ddr_pins, .fet_isolation_ctl, .init_done);
  ddr_dev_model i_mem (.sys_clk, .reset, .ck_run(ddr_clk_run), .pins(ddr_pins), .fet_isolation_ctl,
                       .mode_reg, .ext_reg, .dll_locked, .dll_rst_cnt, .err_count);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(negedge sys_clk);
    chk(what, sw_rdata, exp);
  endtask
  task automatic wait_lvl(input logic v);
    int n = 0;
    while (init_done !== v && n < 6000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("init done", {31'h0, init_done}, {31'h0, v});
  endtask
  function automatic logic [26:0] burst_exp(input int s, input int len, input int il);
    logic [26:0] r;
    r = 27'(s) << 24;
    for (int b = 0; b < len; b++) r[3*b +: 3] = il ? 3'(s ^ b) : 3'((s & ~(len-1)) | ((s + b) & (len-1)));
    return r;
  endfunction
  task automatic init_run(input logic [31:0] ctrl, input logic [7:0] rst, input logic [11:0] mode);
    logic [7:0] r0 = dll_rst_cnt;
    wr(ddr_init_pkg::MODE_OFS, {20'h0, mode});
    wr(ddr_init_pkg::CTRL_OFS, ctrl);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk("dll reset writes", dll_rst_cnt - r0, rst);
    chk("dll locked", dll_locked, 1'b1);
    chk("ext mode reg", ext_reg, 12'h000);
    chk("mode reg", mode_reg, mode);
    chk("protocol errors", err_count, 8'h00);
    rd(ddr_init_pkg::CTRL_OFS, ctrl & 32'h6, "ctrl");
    rd(ddr_init_pkg::STATUS_OFS, {26'h0, 2'h3, ddr_init_pkg::ST_READY}, "status");
    $display("test init %h done", ctrl);
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ddr_init_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rd(ddr_init_pkg::MODE_OFS, 32'(ddr_init_pkg::MODE_RESET), "mode reset");
    rd(ddr_init_pkg::STATUS_OFS, 32'h0, "status reset");
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0, "unmapped");
    $display("test registers done");
    for (int lc = 1; lc < 4; lc++) begin
      for (int il = 0; il < 2; il++) begin
        wr(ddr_init_pkg::MODE_OFS, 32'(il * 8 + lc + 32));
        for (int s = 0; s < 8; s++) begin
          wr(ddr_init_pkg::BURST_OFS, 32'(s));
          rd(ddr_init_pkg::BURST_OFS, {5'h0, burst_exp(s, 1 << lc, il)}, "burst order");
        end
      end
    end
    $display("test burst done");
    init_run(32'h1, 8'h1, 12'h032);
    wr(ddr_init_pkg::MODE_OFS, 32'h2A);
    wr(ddr_init_pkg::CTRL_OFS, 32'h8);
    for (int n = 0; n < 50 && mode_reg !== 12'h02A; n++) @(negedge sys_clk);
    wait_lvl(1'b1);
    chk("rewritten mode", mode_reg, 12'h02A);
    chk("protocol errors", err_count, 8'h00);
    $display("test rewrite done");
    init_run(32'h3, 8'h0, 12'h023);
    init_run(32'h5, 8'h1, 12'h063);
    test_done();
  end
endmodule

bind ddr_init_ctl ddr_init_props i_props (.sys_clk, .reset, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
                                          .sw_rdata, .ddr_clk_run, .ddr_pins, .fet_isolation_ctl, .init_done);
